// ### hdl/dpsem_host.sv
/*
  Semaphore host controller: acquires, releases, polls and initialises the eight
  hardware semaphore tokens of one port of a dual-port memory.
  Assumes the device pins are synchronous to sys_clk_i; the other port is driven
  by an independent party.
*/
`timescale 1ns/10ps
module dpsem_host #(
  parameter int unsigned NUM_SEMS = dpsem_pkg::NUM_SEMS
) (
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic cmd_valid_i,
  input wire dpsem_pkg::dpsem_cmd_t cmd_i,
  input wire logic [dpsem_pkg::IDX_W-1:0] cmd_idx_i,
  output logic cmd_ready_o,
  output logic rsp_valid_o,
  output logic rsp_owned_o,
  output logic [NUM_SEMS-1:0] owned_o,
  output logic semaphore_select_n_o,
  output logic ce_n_o,
  output logic rw_n_o,
  output logic oe_n_o,
  output logic [dpsem_pkg::ADDR_W-1:0] addr_o,
  output logic [dpsem_pkg::DATA_W-1:0] data_o,
  output logic data_oe_o,
  input wire logic [dpsem_pkg::DATA_W-1:0] data_i
);
  typedef enum logic [2:0] {DPSEM_IDLE, DPSEM_WRITE, DPSEM_WAIT_W, DPSEM_READ, DPSEM_WAIT_R,
    DPSEM_ANSWER} dpsem_state_t;

  dpsem_pins_if acc ();
  dpsem_state_t st_q;
  dpsem_pkg::dpsem_cmd_t cmd_q;
  logic [dpsem_pkg::IDX_W-1:0] idx_q;
  logic wbit_q;
  logic ready_q;
  logic rsp_valid_q;
  logic rsp_owned_q;
  logic [NUM_SEMS-1:0] owned_q;
  logic start_q;
  logic wr_q;

  assign acc.start = start_q;
  assign acc.wr = wr_q;
  assign acc.idx = idx_q;
  assign acc.wbit = wbit_q;
  assign cmd_ready_o = ready_q;
  assign rsp_valid_o = rsp_valid_q;
  assign rsp_owned_o = rsp_owned_q;
  assign owned_o = owned_q;

  // Sequencer; every acquire is write zero then read back
  always_ff @(posedge sys_clk_i) begin
    start_q <= 1'b0;
    rsp_valid_q <= 1'b0;
    if (srst_i) begin
      st_q <= DPSEM_IDLE;
      cmd_q <= dpsem_pkg::DPSEM_CMD_POLL;
      idx_q <= '0;
      wbit_q <= dpsem_pkg::FLAG_FREE;
      wr_q <= 1'b0;
      ready_q <= 1'b0;
      rsp_owned_q <= 1'b0;
    end else begin
      unique case (st_q)
        DPSEM_IDLE: begin
          ready_q <= 1'b1;
          if (cmd_valid_i && ready_q) begin
            ready_q <= 1'b0;
            cmd_q <= cmd_i;
            idx_q <= cmd_i == dpsem_pkg::DPSEM_CMD_INIT ? '0 : cmd_idx_i;
            st_q <= cmd_i == dpsem_pkg::DPSEM_CMD_POLL ? DPSEM_READ : DPSEM_WRITE;
          end
        end
        DPSEM_WRITE: begin
          wr_q <= 1'b1;
          wbit_q <= cmd_q == dpsem_pkg::DPSEM_CMD_ACQUIRE ?
            dpsem_pkg::FLAG_TAKE : dpsem_pkg::FLAG_FREE;
          start_q <= 1'b1;
          st_q <= DPSEM_WAIT_W;
        end
        DPSEM_WAIT_W: begin
          if (acc.done) begin
            if (cmd_q == dpsem_pkg::DPSEM_CMD_INIT) begin
              // Free each token in turn from this port
              if (idx_q == dpsem_pkg::IDX_W'(NUM_SEMS - 1)) st_q <= DPSEM_ANSWER;
              else begin
                idx_q <= idx_q + 1'b1;
                st_q <= DPSEM_WRITE;
              end
            end else if (cmd_q == dpsem_pkg::DPSEM_CMD_ACQUIRE) st_q <= DPSEM_READ;
            else st_q <= DPSEM_ANSWER;
          end
        end
        DPSEM_READ: begin
          wr_q <= 1'b0;
          start_q <= 1'b1;
          st_q <= DPSEM_WAIT_R;
        end
        DPSEM_WAIT_R: begin
          if (acc.done) st_q <= DPSEM_ANSWER;
        end
        DPSEM_ANSWER: begin
          rsp_valid_q <= 1'b1;
          rsp_owned_q <= (cmd_q == dpsem_pkg::DPSEM_CMD_ACQUIRE ||
            cmd_q == dpsem_pkg::DPSEM_CMD_POLL) ? owned_q[idx_q] : 1'b0;
          st_q <= DPSEM_IDLE;
        end
        default: st_q <= DPSEM_IDLE;
      endcase
    end
  end

  // Ownership map, read zero means this port holds the token
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      owned_q <= '0;
    end else if (acc.done && !wr_q) begin
      owned_q[idx_q] <= acc.rbit == dpsem_pkg::FLAG_TAKE;
    end else if (acc.done && wr_q && wbit_q == dpsem_pkg::FLAG_FREE) begin
      owned_q[idx_q] <= 1'b0;
    end
  end

  dpsem_pin_drv u_drv (
    .sys_clk_i(sys_clk_i),
    .srst_i(srst_i),
    .acc(acc),
    .semaphore_select_n_q(semaphore_select_n_o),
    .ce_n_q(ce_n_o),
    .rw_n_q(rw_n_o),
    .oe_n_q(oe_n_o),
    .addr_q(addr_o),
    .dout_q(data_o),
    .dout_en_q(data_oe_o),
    .din_i(data_i)
  );

  // Sequencing and ownership checks
  a_acquire_reads_back: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    (st_q == DPSEM_WAIT_W && acc.done && cmd_q == dpsem_pkg::DPSEM_CMD_ACQUIRE)
    |=> st_q == DPSEM_READ) else $error("Acquire not followed by read");

  a_acquire_writes_zero: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    (start_q && wr_q && cmd_q == dpsem_pkg::DPSEM_CMD_ACQUIRE) |-> !wbit_q)
    else $error("Acquire did not write zero");

  a_release_writes_one: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    (start_q && wr_q && cmd_q != dpsem_pkg::DPSEM_CMD_ACQUIRE) |-> wbit_q)
    else $error("Release or init did not write one");

  a_release_clears_own: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    (acc.done && wr_q && wbit_q) |=> !owned_q[$past(idx_q)])
    else $error("Ownership kept after release");

  a_one_answer: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    rsp_valid_q |=> !rsp_valid_q && ready_q) else $error("Answer not single");

  a_acquire_write_first: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    (st_q != DPSEM_IDLE && $past(st_q) == DPSEM_IDLE &&
    cmd_q == dpsem_pkg::DPSEM_CMD_ACQUIRE) |-> st_q == DPSEM_WRITE)
    else $error("Acquire did not start with a write");

  a_init_starts_zero: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    (st_q != DPSEM_IDLE && $past(st_q) == DPSEM_IDLE &&
    cmd_q == dpsem_pkg::DPSEM_CMD_INIT) |-> idx_q == '0)
    else $error("Init did not start at token zero");

  a_init_covers_all: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    (st_q == DPSEM_ANSWER && cmd_q == dpsem_pkg::DPSEM_CMD_INIT) |->
    idx_q == dpsem_pkg::IDX_W'(NUM_SEMS - 1)) else $error("Init ended before last token");

  a_poll_reads_only: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    (start_q && cmd_q == dpsem_pkg::DPSEM_CMD_POLL) |-> !wr_q)
    else $error("Poll issued a write");

  a_release_answer_zero: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    (rsp_valid_q && (cmd_q == dpsem_pkg::DPSEM_CMD_RELEASE ||
    cmd_q == dpsem_pkg::DPSEM_CMD_INIT)) |-> !rsp_owned_q)
    else $error("Release answered owned");

  a_owned_on_done: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    !acc.done |=> $stable(owned_q))
    else $error("Ownership changed without an access");

  a_idle_deselected: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    (st_q == DPSEM_IDLE) |-> semaphore_select_n_o && oe_n_o && rw_n_o)
    else $error("Pins active while idle");

  a_write_launch: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    (st_q == DPSEM_WRITE) |=> start_q && wr_q)
    else $error("Write access not launched");

  a_read_launch: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    (st_q == DPSEM_READ) |=> start_q && !wr_q)
    else $error("Read access not launched");

  a_busy_not_ready: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    (st_q != DPSEM_IDLE) |-> !ready_q)
    else $error("Ready while busy");

  a_answer_after_done: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    (st_q == DPSEM_ANSWER) |-> $past(acc.done))
    else $error("Answer without finished access");
endmodule // dpsem_host

// ### hdl/dpsem_pin_drv.sv
/*
  Pin driver: runs one semaphore write or read cycle on the device pins.
  Assumes device pins are sampled synchronously; data bus is three signals.
*/
`timescale 1ns/10ps
module dpsem_pin_drv (
  input wire logic sys_clk_i,
  input wire logic srst_i,
  dpsem_pins_if.drv acc,
  output logic semaphore_select_n_q,
  output logic ce_n_q,
  output logic rw_n_q,
  output logic oe_n_q,
  output logic [dpsem_pkg::ADDR_W-1:0] addr_q,
  output logic [dpsem_pkg::DATA_W-1:0] dout_q,
  output logic dout_en_q,
  input wire logic [dpsem_pkg::DATA_W-1:0] din_i
);
  typedef enum logic [1:0] {DPSEM_P_IDLE, DPSEM_P_SETUP, DPSEM_P_STROBE, DPSEM_P_GAP} dpsem_ps_t;
  dpsem_ps_t st_q;
  logic [dpsem_pkg::CNT_W-1:0] cnt_q;
  logic wr_q;
  logic done_q;
  logic rbit_q;

  assign acc.done = done_q;
  assign acc.rbit = rbit_q;

  always_ff @(posedge sys_clk_i) begin
    done_q <= 1'b0;
    if (srst_i) begin
      st_q <= DPSEM_P_IDLE;
      cnt_q <= '0;
      wr_q <= 1'b0;
      rbit_q <= 1'b1;
      semaphore_select_n_q <= 1'b1;
      ce_n_q <= 1'b1;
      rw_n_q <= 1'b1;
      oe_n_q <= 1'b1;
      addr_q <= '0;
      dout_q <= '0;
      dout_en_q <= 1'b0;
    end else begin
      ce_n_q <= 1'b1;
      unique case (st_q)
        DPSEM_P_IDLE: begin
          if (acc.start) begin
            wr_q <= acc.wr;
            addr_q <= {{(dpsem_pkg::ADDR_W-dpsem_pkg::IDX_W){1'b0}}, acc.idx};
            dout_q <= {{(dpsem_pkg::DATA_W-1){1'b1}}, acc.wbit};
            dout_en_q <= acc.wr;
            semaphore_select_n_q <= 1'b0;
            cnt_q <= dpsem_pkg::CNT_W'(dpsem_pkg::SETUP_CYC);
            st_q <= DPSEM_P_SETUP;
          end
        end
        DPSEM_P_SETUP: begin
          cnt_q <= cnt_q - 1'b1;
          if (cnt_q == dpsem_pkg::CNT_W'(1)) begin
            if (wr_q) rw_n_q <= 1'b0;
            else oe_n_q <= 1'b0;
            cnt_q <= dpsem_pkg::CNT_W'(dpsem_pkg::STROBE_CYC);
            st_q <= DPSEM_P_STROBE;
          end
        end
        DPSEM_P_STROBE: begin
          cnt_q <= cnt_q - 1'b1;
          if (cnt_q == dpsem_pkg::CNT_W'(1)) begin
            rbit_q <= din_i[0];
            // Deselect after every access so the next read relatches
            semaphore_select_n_q <= 1'b1;
            rw_n_q <= 1'b1;
            oe_n_q <= 1'b1;
            cnt_q <= dpsem_pkg::CNT_W'(dpsem_pkg::GAP_CYC);
            st_q <= DPSEM_P_GAP;
          end
        end
        DPSEM_P_GAP: begin
          dout_en_q <= 1'b0;
          cnt_q <= cnt_q - 1'b1;
          if (cnt_q == dpsem_pkg::CNT_W'(1)) begin
            done_q <= 1'b1;
            st_q <= DPSEM_P_IDLE;
          end
        end
      endcase
    end
  end

  a_deselect_between: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    (done_q |-> semaphore_select_n_q && oe_n_q)) else $error("Select not released");
  a_ce_held_high: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    (!semaphore_select_n_q |-> ce_n_q))
    else $error("Chip enable active in semaphore access");
  a_addr_upper_zero: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    (!semaphore_select_n_q |-> addr_q[dpsem_pkg::ADDR_W-1:dpsem_pkg::IDX_W] == '0))
    else $error("Upper address bits set");
  a_write_drives_bus: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    (!rw_n_q |-> dout_en_q && oe_n_q)) else $error("Write strobe without data drive");
endmodule // dpsem_pin_drv

// ### hdl/dpsem_pins_if.sv
/*
  Interface carrying one pin-level access between the sequencer and the pin driver.
  Assumes both ends sit on the same clock.
*/
`timescale 1ns/10ps
interface dpsem_pins_if;
  logic start;
  logic wr;
  logic [dpsem_pkg::IDX_W-1:0] idx;
  logic wbit;
  logic done;
  logic rbit;
  modport seq (output start, output wr, output idx, output wbit, input done, input rbit);
  modport drv (input start, input wr, input idx, input wbit, output done, output rbit);
endinterface

// ### hdl/dpsem_pkg.sv
/*
  Package of the semaphore host controller: pin timing, flag encoding, commands.
  Assumes one 20 MHz system clock and one port of the dual-port semaphore device.
*/
package dpsem_pkg;
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned NUM_SEMS = 8;
  localparam int unsigned IDX_W = 3;
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 8;
  // Strobe phase lengths, in ns, then cycles (rounded up, at least one)
  localparam int unsigned SETUP_NS = 50;
  localparam int unsigned STROBE_NS = 100;
  localparam int unsigned GAP_NS = 50;
  localparam int unsigned SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned GAP_CYC = (GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W = 4;
  // Flag values: active low
  localparam logic FLAG_TAKE = 1'b0;
  localparam logic FLAG_FREE = 1'b1;
  typedef enum logic [1:0] {DPSEM_CMD_ACQUIRE, DPSEM_CMD_RELEASE, DPSEM_CMD_POLL,
    DPSEM_CMD_INIT} dpsem_cmd_t;
endpackage

// ### verification/dpsem_dev_model.sv
/*
  Two-port semaphore unit model: eight tokens, request latches, frozen reads.
  Assumes port pins are steady at each rising clk_i; port A is the host.
*/
`timescale 1ns/10ps
module dpsem_dev_model (
  input wire logic clk_i,
  input wire logic a_cs_n_i,
  input wire logic a_ce_n_i,
  input wire logic a_we_n_i,
  input wire logic a_oe_n_i,
  input wire logic [15:0] a_adr_i,
  input wire logic [7:0] a_d_i,
  output logic [7:0] a_q_o,
  input wire logic b_cs_n_i,
  input wire logic b_we_n_i,
  input wire logic b_oe_n_i,
  input wire logic [2:0] b_idx_i,
  input wire logic b_d_i,
  output logic [7:0] b_q_o
);
  // No power-up clear: every request starts pending
  logic [7:0] req_a = 8'h00, req_b = 8'h00, own_a = 8'h00, own_b = 8'h00;
  logic [7:0] last_a = 8'h00, last_b = 8'h00;
  logic lat_a = 1'b1, lat_b = 1'b1, a_rd_q = 1'b0, b_rd_q = 1'b0, a_rd, b_rd;
  assign a_rd = !a_cs_n_i && a_ce_n_i && !a_oe_n_i && a_we_n_i;
  assign b_rd = !b_cs_n_i && !b_oe_n_i && b_we_n_i;
  // Released bus shows the inverse of its last value
  assign a_q_o = a_rd ? {8{lat_a}} : ~last_a;
  assign b_q_o = b_rd ? {8{lat_b}} : ~last_b;
  always @(posedge clk_i) begin
    if (!a_cs_n_i && a_ce_n_i && !a_we_n_i) req_a[a_adr_i[2:0]] = a_d_i[0];
    if (!b_cs_n_i && !b_we_n_i) req_b[b_idx_i] = b_d_i;
    for (int i = 0; i < 8; i++) begin
      if (own_a[i] && req_a[i]) own_a[i] = 1'b0;
      if (own_b[i] && req_b[i]) own_b[i] = 1'b0;
      // Pending request takes a freed token; a tie goes to port A
      if (!own_a[i] && !own_b[i] && !req_a[i]) own_a[i] = 1'b1;
      else if (!own_a[i] && !own_b[i] && !req_b[i]) own_b[i] = 1'b1;
    end
    if (a_rd && !a_rd_q) lat_a <= !own_a[a_adr_i[2:0]];
    if (b_rd && !b_rd_q) lat_b <= !own_b[b_idx_i];
    if (a_rd) last_a <= {8{lat_a}};
    if (b_rd) last_b <= {8{lat_b}};
    a_rd_q <= a_rd;
    b_rd_q <= b_rd;
  end
endmodule // dpsem_dev_model

// ### verification/dpsem_host_tb.sv
/*
  Self-checking bench of the semaphore host against the two-port device model.
  Assumes the bench works the model's second port directly.
*/
`timescale 1ns/10ps
module dpsem_host_tb;
  logic clk = 1'b0, srst = 1'b1, cv = 1'b0, rdy, rv, ro, sel_n, ce_n, rw_n, oe_n, doe;
  logic bs_n = 1'b1, bw_n = 1'b1, bo_n = 1'b1, bb = 1'b1;
  logic [2:0] ci = 3'h0, bi = 3'h0;
  logic [7:0] own, dq, din, bq;
  logic [15:0] addr;
  dpsem_pkg::dpsem_cmd_t cmd = dpsem_pkg::DPSEM_CMD_POLL;
  int n_errors = 0, total_checks = 0, cyc = 0;
  initial begin
    forever #25 clk = ~clk;
  end
  dpsem_host dut_u (.sys_clk_i(clk), .srst_i(srst), .cmd_valid_i(cv), .cmd_i(cmd),
    .cmd_idx_i(ci), .cmd_ready_o(rdy), .rsp_valid_o(rv), .rsp_owned_o(ro), .owned_o(own),
    .semaphore_select_n_o(sel_n), .ce_n_o(ce_n), .rw_n_o(rw_n), .oe_n_o(oe_n),
    .addr_o(addr), .data_o(dq), .data_oe_o(doe), .data_i(din));
  dpsem_dev_model dev_u (.clk_i(clk), .a_cs_n_i(sel_n), .a_ce_n_i(ce_n), .a_we_n_i(rw_n),
    .a_oe_n_i(oe_n), .a_adr_i(addr), .a_d_i(dq), .a_q_o(din), .b_cs_n_i(bs_n),
    .b_we_n_i(bw_n), .b_oe_n_i(bo_n), .b_idx_i(bi), .b_d_i(bb), .b_q_o(bq));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t %s: got %h expected %h", $time, msg, got, exp);
    end
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic hcmd(input dpsem_pkg::dpsem_cmd_t c, input logic [2:0] i, input logic e,
      input logic [7:0] em);
    int n;
    @(posedge clk);
    cv <= 1'b1;
    cmd <= c;
    ci <= i;
    @(posedge clk);
    for (n = 0; n < 20 && rdy !== 1'b1; n++) @(posedge clk);
    cv <= 1'b0;
    for (n = 0; n < 300 && rv !== 1'b1; n++) @(posedge clk);
    chk({7'h00, rv}, 8'h01, "response valid");
    chk({7'h00, ro}, {7'h00, e}, "command result");
    @(posedge clk);
    chk(own, em, "ownership map");
  endtask
  task automatic bfree();
    bs_n <= 1'b1;
    bw_n <= 1'b1;
    bo_n <= 1'b1;
  endtask
  task automatic bacc(input logic [2:0] i, input logic w, input logic v, input logic [7:0] e,
      input logic keep);
    @(posedge clk);
    bs_n <= 1'b0;
    bi <= i;
    bb <= v;
    bw_n <= !w;
    bo_n <= w;
    repeat (2) @(posedge clk);
    if (!w) chk(bq, e, "port b flag");
    if (!keep) bfree();
  endtask
  task automatic t_init();
    chk({sel_n, ce_n, rw_n, oe_n, doe, rv, rdy, 1'b0}, 8'hF0, "idle pins");
    hcmd(dpsem_pkg::DPSEM_CMD_INIT, 3'h0, 1'b0, 8'h00);
    for (int i = 0; i < 8; i++) begin
      bacc(3'(i), 1'b1, 1'b1, 8'h00, 1'b0);
      bacc(3'(i), 1'b0, 1'b0, 8'hFF, 1'b0);
    end
    $display("test init done");
  endtask
  task automatic t_own();
    hcmd(dpsem_pkg::DPSEM_CMD_ACQUIRE, 3'h3, 1'b1, 8'h08);
    bacc(3'h3, 1'b1, 1'b0, 8'h00, 1'b0);
    bacc(3'h3, 1'b0, 1'b0, 8'hFF, 1'b1);
    hcmd(dpsem_pkg::DPSEM_CMD_RELEASE, 3'h3, 1'b0, 8'h00);
    chk(bq, 8'hFF, "frozen read");
    bfree();
    bacc(3'h3, 1'b0, 1'b0, 8'h00, 1'b0);
    hcmd(dpsem_pkg::DPSEM_CMD_ACQUIRE, 3'h3, 1'b0, 8'h00);
    hcmd(dpsem_pkg::DPSEM_CMD_POLL, 3'h3, 1'b0, 8'h00);
    bacc(3'h3, 1'b1, 1'b1, 8'h00, 1'b0);
    hcmd(dpsem_pkg::DPSEM_CMD_POLL, 3'h3, 1'b1, 8'h08);
    hcmd(dpsem_pkg::DPSEM_CMD_RELEASE, 3'h3, 1'b0, 8'h00);
    bacc(3'h3, 1'b0, 1'b0, 8'hFF, 1'b0);
    $display("test ownership done");
  endtask
  task automatic t_all();
    logic [7:0] m;
    m = 8'h00;
    for (int i = 0; i < 8; i++) begin
      m[i] = 1'b1;
      hcmd(dpsem_pkg::DPSEM_CMD_ACQUIRE, 3'(i), 1'b1, m);
      bacc(3'(i), 1'b0, 1'b0, 8'hFF, 1'b0);
    end
    hcmd(dpsem_pkg::DPSEM_CMD_INIT, 3'h0, 1'b0, 8'h00);
    bacc(3'h5, 1'b0, 1'b0, 8'hFF, 1'b0);
    $display("test all tokens done");
  endtask
  always @(posedge clk) begin
    cyc++;
    if (!srst && !sel_n) begin
      total_checks++;
      if (ce_n !== 1'b1 || addr[15:3] !== 13'h0000) begin
        n_errors++;
        $display("ERROR %0t select with low enable or high address bits", $time);
      end
    end
    if (!srst && !rw_n) begin
      total_checks++;
      if (doe !== 1'b1 || oe_n !== 1'b1 || dq[7:1] !== 7'h7F) begin
        n_errors++;
        $display("ERROR %0t write strobe without full data drive", $time);
      end
    end
    if (cyc == 5000) begin
      n_errors++;
      $display("ERROR %0t timeout", $time);
      summarize();
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    t_init();
    t_own();
    t_all();
    summarize();
  end
endmodule // dpsem_host_tb
